// file: design/sfr_defs.svh
// Overview of operation
// - a bit-order value of 0 sends each byte high bit first, 1 sends it low bit first.
// - phase 0 samples on the leading clock edge and shifts on the trailing one; 1 the reverse.
// - polarity 0 means the serial clock idles low (active high); 1 means it idles high.
// - a transaction without a granted buffer shifts out the ignored-transaction fill char.
// - every byte the master clocks past the buffer's end in a granted transaction is the over-read fill character.
// - the byte limit caps how many buffer bytes are sent; the over-read char follows it.
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SFR_OFF_LIMIT 12'h548
`define SFR_OFF_AMOUNT 12'h54c
`define SFR_OFF_LIST 12'h550
`define SFR_OFF_CFG 12'h554
`define SFR_OFF_IGN_FILL 12'h55c
`define SFR_OFF_CTRL 12'h560
`define SFR_OFF_OVR_FILL 12'h5c0
`define SFR_OFF_BUF 12'h600

// ****************************************
// field positions, widths and reset values
// ****************************************
`define SFR_CFG_ORDER 0
`define SFR_CFG_CPHA 1
`define SFR_CFG_CPOL 2
`define SFR_CTRL_GRANT 0
`define SFR_CTRL_BUSY 1
`define SFR_LIMIT_W 14
`define SFR_LIST_W 2
`define SFR_RST_WORD 32'h0000_0000

`endif

// file: design/sfr_pkg.sv
package sfr_pkg;
    // link ownership seen from the system clock
    typedef enum {SFR_IDLE, SFR_FRAME} sfr_link_t;
    typedef logic [7:0] sfr_byte_t;
endpackage : sfr_pkg

// file: design/sfr_shifter.sv
`timescale 1ns/1ps
module sfr_shifter
    import sfr_pkg::*;
#(
    parameter int CNT_W = 19
) (
    input wire logic i_spi_sck,
    input wire logic i_link_hold,
    input wire logic i_cpha,
    input wire logic i_cpol,
    input wire logic i_low_bit_first,
    input wire sfr_byte_t i_tx_byte,
    output logic [CNT_W-4:0] o_byte_idx,
    output logic [CNT_W-1:0] o_bits,
    output logic o_miso
);
    logic [CNT_W-1:0] pos_cnt;
    logic [CNT_W-1:0] neg_cnt;
    logic samp_pos;
    logic [CNT_W-1:0] shift_cnt;
    logic [CNT_W-1:0] out_idx;

    // pick one bit of a byte for a given bit count
    function automatic logic pick(input sfr_byte_t b, input logic [2:0] c, input logic lsb);
        return lsb ? b[c] : b[3'd7 - c];
    endfunction : pick

    // ****************************************
    // edge counters, held clear between frames
    // ****************************************
    // counters stay put after select rises so the system side can read them
    always_ff @(posedge i_spi_sck or posedge i_link_hold) begin
        if (i_link_hold) begin
            pos_cnt <= '0;
        end else begin
            pos_cnt <= pos_cnt + 1'b1;
        end
    end

    always_ff @(negedge i_spi_sck or posedge i_link_hold) begin
        if (i_link_hold) begin
            neg_cnt <= '0;
        end else begin
            neg_cnt <= neg_cnt + 1'b1;
        end
    end

    // sample edge choice
    // rising is the sample edge in modes 0 and 3
    assign samp_pos = (i_cpol == i_cpha);
    assign o_bits = samp_pos ? pos_cnt : neg_cnt;
    assign shift_cnt = samp_pos ? neg_cnt : pos_cnt;

    // bit shown on the line
    // both phases show bit 0 before any edge; phase 1 keeps it through the first shift
    always_comb begin
        out_idx = shift_cnt;
        if (i_cpha && shift_cnt != '0) begin
            out_idx = shift_cnt - 1'b1;
        end
    end
    assign o_byte_idx = out_idx[CNT_W-1:3];

    // bit order of the outgoing byte
    assign o_miso = pick(i_tx_byte, out_idx[2:0], i_low_bit_first);

    // ****************************************
    // link-side checks
    // ****************************************
    high_first_a: assert property (@(posedge i_spi_sck) disable iff (i_link_hold)
        (!i_low_bit_first && out_idx[2:0] == 3'd0) |-> o_miso == i_tx_byte[7])
        else $error("high bit not first");
    low_first_a: assert property (@(negedge i_spi_sck) disable iff (i_link_hold)
        (i_low_bit_first && out_idx[2:0] == 3'd0) |-> o_miso == i_tx_byte[0])
        else $error("low bit not first");
    lead_sample_a: assert property (@(posedge i_spi_sck) disable iff (i_link_hold)
        (samp_pos && !i_cpha && pos_cnt == '0) |->
        o_miso == (i_low_bit_first ? i_tx_byte[0] : i_tx_byte[7]))
        else $error("first bit not ready at leading edge");
    idle_level_a: assert property (@(posedge i_spi_sck) disable iff (i_link_hold)
        !i_cpol |-> neg_cnt == pos_cnt)
        else $error("clock polarity order broken");
endmodule : sfr_shifter

// file: design/sfr_regs_top.sv
`timescale 1ns/1ps
`include "sfr_defs.svh"
module sfr_regs_top
    import sfr_pkg::*;
#(
    parameter int BUF_DEPTH = 16,
    parameter int CNT_W = 19
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_spi_sck,
    input wire logic i_slave_select_n,
    output logic o_miso,
    output logic o_miso_oe_n
);
    localparam int BW = $clog2(BUF_DEPTH);
    localparam int LW = `SFR_LIMIT_W;
    localparam logic [LW-1:0] DEPTH_L = LW'(BUF_DEPTH);

    // ****************************************
    // declarations
    // ****************************************
    logic ss_meta;
    logic ss_sync;
    logic ap_valid;
    logic ap_write;
    logic [11:0] ap_addr;
    logic take;
    logic wr;
    logic [31:0] rd_val;
    logic [LW-1:0] tx_byte_limit;
    logic [LW-1:0] tx_amount;
    logic [`SFR_LIST_W-1:0] array_list_mode;
    logic [2:0] cfg;
    sfr_byte_t ignored_txn_fill_char;
    sfr_byte_t overread_fill_char;
    logic grant;
    sfr_byte_t tx_buf [BUF_DEPTH];
    sfr_link_t link_state;
    logic link_hold;
    logic frame_end;
    logic [2:0] cfg_s;
    sfr_byte_t ign_fill_s;
    sfr_byte_t ovr_fill_s;
    logic grant_s;
    logic [LW-1:0] lim_s;
    sfr_byte_t tx_byte;
    logic [CNT_W-4:0] byte_idx;
    logic [CNT_W-1:0] bits;
    logic [CNT_W-4:0] sent;

    // word match on a register offset
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a[11:2] == off[11:2];
    endfunction : hit

    // match inside the transmit buffer window
    function automatic logic buf_hit(input logic [11:0] a);
        return a >= `SFR_OFF_BUF && a < (`SFR_OFF_BUF + 12'(4 * BUF_DEPTH));
    endfunction : buf_hit

    // ****************************************
    // select synchroniser
    // ****************************************
    // idle high so a reset never looks like a frame
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ss_meta <= 1'b1;
            ss_sync <= 1'b1;
        end else begin
            ss_meta <= i_slave_select_n;
            ss_sync <= ss_meta;
        end
    end

    // ****************************************
    // bus slave
    // ****************************************
    // zero wait states: data phase always completes at once
    assign take = i_hsel && i_htrans[1] && i_hready;
    assign wr = ap_valid && ap_write;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= '0;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            ap_valid <= take;
            ap_write <= i_hwrite;
            ap_addr <= i_haddr[11:0];
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // read decode in the address phase, unmapped reads as zero
    always_comb begin
        rd_val = `SFR_RST_WORD;
        if (hit(i_haddr[11:0], `SFR_OFF_LIMIT)) begin
            rd_val[LW-1:0] = tx_byte_limit;
        end else if (hit(i_haddr[11:0], `SFR_OFF_AMOUNT)) begin
            rd_val[LW-1:0] = tx_amount;
        end else if (hit(i_haddr[11:0], `SFR_OFF_LIST)) begin
            rd_val[`SFR_LIST_W-1:0] = array_list_mode;
        end else if (hit(i_haddr[11:0], `SFR_OFF_CFG)) begin
            rd_val[2:0] = cfg;
        end else if (hit(i_haddr[11:0], `SFR_OFF_IGN_FILL)) begin
            rd_val[7:0] = ignored_txn_fill_char;
        end else if (hit(i_haddr[11:0], `SFR_OFF_OVR_FILL)) begin
            rd_val[7:0] = overread_fill_char;
        end else if (hit(i_haddr[11:0], `SFR_OFF_CTRL)) begin
            rd_val[`SFR_CTRL_GRANT] = grant;
            rd_val[`SFR_CTRL_BUSY] = (link_state == SFR_FRAME);
        end else if (buf_hit(i_haddr[11:0])) begin
            rd_val[7:0] = tx_buf[i_haddr[BW+1:2]];
        end
    end

    // read data registered for the data phase
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_hrdata <= `SFR_RST_WORD;
        end else if (take && !i_hwrite) begin
            o_hrdata <= rd_val;
        end else begin
            o_hrdata <= `SFR_RST_WORD;
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    // plain settings written in the data phase
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            tx_byte_limit <= '0;
            array_list_mode <= '0;
            cfg <= '0;
            ignored_txn_fill_char <= '0;
            overread_fill_char <= '0;
        end else if (wr) begin
            if (hit(ap_addr, `SFR_OFF_LIMIT)) begin
                tx_byte_limit <= i_hwdata[LW-1:0];
            end
            if (hit(ap_addr, `SFR_OFF_LIST)) begin
                array_list_mode <= i_hwdata[`SFR_LIST_W-1:0];
            end
            if (hit(ap_addr, `SFR_OFF_CFG)) begin
                cfg <= i_hwdata[2:0];
            end
            if (hit(ap_addr, `SFR_OFF_IGN_FILL)) begin
                ignored_txn_fill_char <= i_hwdata[7:0];
            end
            if (hit(ap_addr, `SFR_OFF_OVR_FILL)) begin
                overread_fill_char <= i_hwdata[7:0];
            end
        end
    end

    // buffer writes are dropped while the link owns it
    always_ff @(posedge i_clk) begin
        if (wr && !grant && buf_hit(ap_addr)) begin
            tx_buf[ap_addr[BW+1:2]] <= i_hwdata[7:0];
        end
    end

    // buffer grant
    // granting needs an idle link; a grant write in the frame-end cycle wins
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            grant <= 1'b0;
        end else if (wr && hit(ap_addr, `SFR_OFF_CTRL) && i_hwdata[`SFR_CTRL_GRANT]
                     && ss_sync) begin
            grant <= 1'b1;
        end else if (frame_end && grant_s) begin
            grant <= 1'b0;
        end
    end

    // ****************************************
    // frame tracking
    // ****************************************
    assign frame_end = (link_state == SFR_FRAME) && ss_sync;

    // link counters are held clear while idle, released once select is seen low
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            link_state <= SFR_IDLE;
            link_hold <= 1'b1;
        end else begin
            case (link_state)
                SFR_IDLE: begin
                    if (!ss_sync) begin
                        link_state <= SFR_FRAME;
                        link_hold <= 1'b0;
                    end
                end
                SFR_FRAME: begin
                    if (ss_sync) begin
                        link_state <= SFR_IDLE;
                        link_hold <= 1'b1;
                    end
                end
                default: begin
                    link_state <= SFR_IDLE;
                    link_hold <= 1'b1;
                end
            endcase
        end
    end

    // settings snapshot
    // the link only sees these copies, frozen for the whole frame
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cfg_s <= '0;
            ign_fill_s <= '0;
            ovr_fill_s <= '0;
            grant_s <= 1'b0;
            lim_s <= '0;
        end else if (link_state == SFR_IDLE && ss_sync) begin
            cfg_s <= cfg;
            ign_fill_s <= ignored_txn_fill_char;
            ovr_fill_s <= overread_fill_char;
            grant_s <= grant;
            lim_s <= (tx_byte_limit < DEPTH_L) ? tx_byte_limit : DEPTH_L;
        end
    end

    // bytes sent from the buffer
    // counters are quiet once select is high, so reading them here is safe
    assign sent = bits[CNT_W-1:3];
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            tx_amount <= '0;
        end else if (frame_end && grant_s) begin
            tx_amount <= (sent > (CNT_W-3)'(lim_s)) ? lim_s : sent[LW-1:0];
        end
    end

    // ****************************************
    // byte source for the link
    // ****************************************
    // fill choice
    // byte index is stable between shift edges, the choice follows it
    always_comb begin
        if (!grant_s) begin
            tx_byte = ign_fill_s;
        end else if (byte_idx < (CNT_W-3)'(lim_s)) begin
            tx_byte = tx_buf[byte_idx[BW-1:0]];
        end else begin
            tx_byte = ovr_fill_s;
        end
    end

    sfr_shifter #(
        .CNT_W(CNT_W)
    ) u_shift (
        .i_spi_sck(i_spi_sck),
        .i_link_hold(link_hold),
        .i_cpha(cfg_s[`SFR_CFG_CPHA]),
        .i_cpol(cfg_s[`SFR_CFG_CPOL]),
        .i_low_bit_first(cfg_s[`SFR_CFG_ORDER]),
        .i_tx_byte(tx_byte),
        .o_byte_idx(byte_idx),
        .o_bits(bits),
        .o_miso(o_miso)
    );

    // line released as soon as select goes high, no clock needed
    assign o_miso_oe_n = i_slave_select_n;

    // ****************************************
    // system-side checks
    // ****************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    ignored_fill_a: assert property (
        (link_state == SFR_FRAME && !grant_s) |-> tx_byte == ign_fill_s)
        else $error("ignored frame not sending fill char");

    overread_fill_a: assert property (
        (grant_s && byte_idx >= (CNT_W-3)'(lim_s)) |-> tx_byte == ovr_fill_s)
        else $error("over-read byte not fill char");

    // amount capped by limit
    // a grant write in the frame-end cycle wins, so the grant may stay then
    amount_cap_a: assert property (
        (frame_end && grant_s) |=>
        (tx_amount <= lim_s && (!grant || $past(wr && hit(ap_addr, `SFR_OFF_CTRL)))))
        else $error("amount beyond limit or grant kept");

    limit_copy_a: assert property (
        (link_state == SFR_IDLE && ss_sync && tx_byte_limit < DEPTH_L)
        |=> lim_s == $past(tx_byte_limit))
        else $error("limit not copied while idle");

    frozen_cfg_a: assert property (
        (link_state == SFR_FRAME) ##1 (link_state == SFR_FRAME)
        |-> $stable(cfg_s) && $stable(ign_fill_s) && $stable(ovr_fill_s) && $stable(grant_s))
        else $error("settings changed mid-frame");

    idle_copy_a: assert property (
        (ss_sync && link_state == SFR_IDLE) |=> cfg_s == $past(cfg))
        else $error("config not copied while idle");
endmodule : sfr_regs_top

// file: tb/sfr_spi_master.sv
`timescale 1ns/1ps
// ****************************************
// behavioural serial master, 160 ns clock
// ****************************************
module sfr_spi_master (
    output logic o_sck,
    output logic o_select_n,
    input wire logic i_miso
);
    logic [7:0] rx [0:7];

    initial begin
        o_sck = 1'b0;
        o_select_n = 1'b1;
    end

    // one framed transfer of n bytes; bits land in arrival order, first at the top
    task frame(input int n, input logic cpol, input logic cpha);
        logic b;
        o_sck = cpol;
        #3;
        o_select_n = 1'b0;
        // 100 ns lead keeps clear of the select synchroniser latency
        #100;
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < 8; k++) begin
                #80;
                // sample leading when phase 0, just before the edge to avoid races
                b = i_miso;
                if (!cpha) rx[i] = {rx[i][6:0], b};
                o_sck = ~cpol;
                #80;
                b = i_miso;
                if (cpha) rx[i] = {rx[i][6:0], b};
                o_sck = cpol;
            end
        end
        #100;
        o_select_n = 1'b1;
        // idle gap long enough for the system side to close the frame
        #400;
    endtask : frame
endmodule : sfr_spi_master

// file: tb/test_spi_slave_format_fill_regs.sv
`timescale 1ns/1ps
`include "sfr_defs.svh"
module test_spi_slave_format_fill_regs;
    import sfr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic sck;
    logic sel_n;
    logic miso;
    logic miso_oe_n;
    logic [31:0] rd;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    sfr_regs_top dut (.i_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_spi_sck(sck), .i_slave_select_n(sel_n), .o_miso(miso), .o_miso_oe_n(miso_oe_n));

    sfr_spi_master spi (.o_sck(sck), .o_select_n(sel_n), .i_miso(miso));

    // ****************************************
    // checking and bus helpers
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // single word transfer, address phase then data phase, both wait on hready
    task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : ahb

    function automatic logic [7:0] arrival(input logic [7:0] b, input logic low_first);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = b[7-i];
        return low_first ? r : b;
    endfunction : arrival

    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        logic [11:0] offs [0:3];
        logic [31:0] msk [0:3];
        offs = '{`SFR_OFF_LIST, `SFR_OFF_CFG, `SFR_OFF_IGN_FILL, `SFR_OFF_OVR_FILL};
        msk = '{32'h3, 32'h7, 32'hff, 32'hff};
        for (int i = 0; i < 4; i++) begin
            ahb(1'b0, offs[i], 32'h0);
            chk(rd, 32'h0); // reset value
            ahb(1'b1, offs[i], 32'hffff_ffff);
            ahb(1'b0, offs[i], 32'h0);
            chk(rd, msk[i]); // read back
        end
        ahb(1'b1, 12'h700, 32'h1234_5678);
        ahb(1'b0, 12'h700, 32'h0);
        chk(rd, 32'h0); // unmapped reads zero
        ahb(1'b1, `SFR_OFF_CFG, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task t_ignored;
        for (int m = 0; m < 8; m++) begin
            ahb(1'b1, `SFR_OFF_CFG, m);
            ahb(1'b1, `SFR_OFF_IGN_FILL, 32'hc5);
            spi.frame(2, m[2], m[1]);
            chk(spi.rx[0], arrival(8'hc5, m[0]));
            chk(spi.rx[1], arrival(8'hc5, m[0]));
        end
        $display("test ignored fill done");
    endtask : t_ignored

    task t_grant;
        ahb(1'b1, `SFR_OFF_CFG, 32'h5);
        ahb(1'b1, `SFR_OFF_BUF, 32'h96);
        ahb(1'b1, `SFR_OFF_BUF + 12'h4, 32'h2d);
        ahb(1'b1, `SFR_OFF_BUF + 12'h8, 32'h71);
        ahb(1'b1, `SFR_OFF_LIMIT, 32'h2);
        ahb(1'b1, `SFR_OFF_OVR_FILL, 32'he8);
        ahb(1'b1, `SFR_OFF_CTRL, 32'h1);
        ahb(1'b0, `SFR_OFF_CTRL, 32'h0);
        chk(rd, 32'h1);
        spi.frame(4, 1'b1, 1'b0);
        chk(spi.rx[0], arrival(8'h96, 1'b1));
        chk(spi.rx[1], arrival(8'h2d, 1'b1));
        chk(spi.rx[2], arrival(8'he8, 1'b1));
        chk(spi.rx[3], arrival(8'he8, 1'b1));
        ahb(1'b0, `SFR_OFF_AMOUNT, 32'h0);
        chk(rd, 32'h2);
        ahb(1'b0, `SFR_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        $display("test granted buffer done");
    endtask : t_grant

    task t_freeze;
        ahb(1'b1, `SFR_OFF_CFG, 32'h0);
        ahb(1'b1, `SFR_OFF_IGN_FILL, 32'h5a);
        fork
            spi.frame(2, 1'b0, 1'b0);
            begin
                repeat (40) @(posedge clk);
                chk({31'h0, miso_oe_n}, 32'h0);
                ahb(1'b1, `SFR_OFF_IGN_FILL, 32'h0f);
                ahb(1'b1, `SFR_OFF_CFG, 32'h1);
                // grant write must be refused while the frame runs
                ahb(1'b1, `SFR_OFF_CTRL, 32'h1);
                ahb(1'b0, `SFR_OFF_CTRL, 32'h0);
                chk(rd, 32'h2);
            end
        join
        chk({31'h0, miso_oe_n}, 32'h1);
        chk(spi.rx[0], 32'h5a);
        chk(spi.rx[1], 32'h5a);
        spi.frame(1, 1'b0, 1'b0);
        chk(spi.rx[0], arrival(8'h0f, 1'b1));
        $display("test frozen settings done");
    endtask : t_freeze

    // ****************************************
    // verdict and hang guard
    // ****************************************
    task print_verdict;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // whole run is well below this many cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_ignored();
        t_grant();
        t_freeze();
        print_verdict();
    end
endmodule : test_spi_slave_format_fill_regs
